/* File: hdl/mal_alu.sv */
// Arithmetic and logic execution unit of an 8-bit core
`timescale 1ns/1ps
`default_nettype none
`include "mal_defs.svh"
module mal_alu (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic start,
  input wire mal_pkg::mal_op_e op,
  input wire logic [7:0] dst_val,
  input wire logic [7:0] dst_hi_val,
  input wire logic [7:0] source_reg,
  input wire logic [7:0] flags_in,
  output logic busy_q,
  output logic done_q,
  output logic [15:0] result_q,
  output logic [7:0] flags_q,
  output logic wide_q,
  output logic product_pair_q
);
  function automatic logic fn_two_cycle(input mal_pkg::mal_op_e o);
    fn_two_cycle = (o == mal_pkg::OP_PAIR_PLUS_IMMEDIATE) || (o == mal_pkg::OP_PAIR_MINUS_IMMEDIATE) ||
                   (o >= mal_pkg::OP_UNSIGNED_PRODUCT);
  endfunction

  // Updates Z, N, V and the sign flag for byte results
  function automatic logic [7:0] fn_znv(input logic [7:0] f, input logic [7:0] r, input logic v);
    logic [7:0] t;
    t = f;
    t[`MAL_FLAG_Z] = (r == 8'h00);
    t[`MAL_FLAG_N] = r[7];
    t[`MAL_FLAG_V] = v;
    t[`MAL_FLAG_S] = r[7] ^ v;
    fn_znv = t;
  endfunction

  mal_pkg::mal_state_e state_q, state_d;
  wire take = start && (state_q == mal_pkg::ST_IDLE);
  wire two = fn_two_cycle(op);
  wire cin = flags_in[`MAL_FLAG_C];

  // Adder with optional carry
  wire add_c = (op == mal_pkg::OP_ADD_CARRY) && cin;
  wire [8:0] add9 = {1'h0, dst_val} + {1'h0, source_reg} + {8'h00, add_c};
  wire [7:0] add_r = add9[7:0];

  // Subtractor shared by subtract, subtract constant and negate
  wire is_neg = (op == mal_pkg::OP_TWOS_COMPLEMENT_NEGATE);
  wire sub_c = ((op == mal_pkg::OP_DIFFERENCE_WITH_BORROW) || (op == mal_pkg::OP_DIFFERENCE_CONST_BORROW)) && cin;
  wire [7:0] sa = is_neg ? 8'h00 : dst_val;
  wire [7:0] sb = is_neg ? dst_val : source_reg;
  wire [8:0] sub9 = {1'h0, sa} - {1'h0, sb} - {8'h00, sub_c};
  wire [7:0] sub_r = sub9[7:0];

  // Register pair arithmetic with a 6-bit immediate
  wire [15:0] pair = {dst_hi_val, dst_val};
  wire [15:0] imm16 = {10'h000, source_reg[`MAL_IMM_BITS-1:0]};
  wire [15:0] padd = pair + imm16;
  wire [15:0] psub = pair - imm16;

  // Multiplier: operand signedness per variant
  wire a_sgn = (op == mal_pkg::OP_SIGNED_PRODUCT) || (op == mal_pkg::OP_MIXED_PRODUCT) ||
               (op == mal_pkg::OP_FRACTIONAL_SIGNED_PRODUCT) || (op == mal_pkg::OP_FRACTIONAL_MIXED_PRODUCT);
  wire b_sgn = (op == mal_pkg::OP_SIGNED_PRODUCT) || (op == mal_pkg::OP_FRACTIONAL_SIGNED_PRODUCT);
  wire signed [8:0] ma = $signed({a_sgn & dst_val[7], dst_val});
  wire signed [8:0] mb = $signed({b_sgn & source_reg[7], source_reg});
  wire signed [17:0] prod_full = ma * mb;
  wire [15:0] prod = prod_full[15:0];
  wire frac = (op >= mal_pkg::OP_FRACTIONAL_UNSIGNED_PRODUCT);
  wire [15:0] prod_out = frac ? {prod[14:0], 1'h0} : prod;

  logic [15:0] res_d;
  logic [7:0] fl_d;
  logic wide_d;
  logic prodp_d;

  always_comb begin
    res_d = {8'h00, dst_val};
    fl_d = flags_in;
    wide_d = 1'h0;
    prodp_d = 1'h0;
    case (op)
      mal_pkg::OP_ADD, mal_pkg::OP_ADD_CARRY: begin
        res_d = {8'h00, add_r};
        fl_d = fn_znv(flags_in, add_r, (dst_val[7] & source_reg[7] & ~add_r[7]) |
                      (~dst_val[7] & ~source_reg[7] & add_r[7]));
        fl_d[`MAL_FLAG_C] = add9[8];
        fl_d[`MAL_FLAG_H] = (dst_val[3] & source_reg[3]) | (source_reg[3] & ~add_r[3]) |
                            (~add_r[3] & dst_val[3]);
      end
      mal_pkg::OP_SUB, mal_pkg::OP_DIFFERENCE_CONST, mal_pkg::OP_DIFFERENCE_WITH_BORROW,
      mal_pkg::OP_DIFFERENCE_CONST_BORROW, mal_pkg::OP_TWOS_COMPLEMENT_NEGATE: begin
        res_d = {8'h00, sub_r};
        fl_d = fn_znv(flags_in, sub_r, (sa[7] & ~sb[7] & ~sub_r[7]) | (~sa[7] & sb[7] & sub_r[7]));
        fl_d[`MAL_FLAG_C] = sub9[8];
        fl_d[`MAL_FLAG_H] = (~sa[3] & sb[3]) | (sb[3] & sub_r[3]) | (sub_r[3] & ~sa[3]);
        if (sub_c || (op == mal_pkg::OP_DIFFERENCE_WITH_BORROW) || (op == mal_pkg::OP_DIFFERENCE_CONST_BORROW)) begin
          // Borrowing forms keep Z only while the whole chain is zero
          fl_d[`MAL_FLAG_Z] = (sub_r == 8'h00) & flags_in[`MAL_FLAG_Z];
        end
      end
      mal_pkg::OP_PAIR_PLUS_IMMEDIATE: begin
        res_d = padd;
        wide_d = 1'h1;
        fl_d = fn_znv(flags_in, padd[15:8], ~dst_hi_val[7] & padd[15]);
        fl_d[`MAL_FLAG_Z] = (padd == 16'h0000);
        fl_d[`MAL_FLAG_C] = ~padd[15] & dst_hi_val[7];
      end
      mal_pkg::OP_PAIR_MINUS_IMMEDIATE: begin
        res_d = psub;
        wide_d = 1'h1;
        fl_d = fn_znv(flags_in, psub[15:8], dst_hi_val[7] & ~psub[15]);
        fl_d[`MAL_FLAG_Z] = (psub == 16'h0000);
        fl_d[`MAL_FLAG_C] = psub[15] & ~dst_hi_val[7];
      end
      mal_pkg::OP_AND, mal_pkg::OP_BITWISE_CONJ_CONST: begin
        res_d = {8'h00, dst_val & source_reg};
        fl_d = fn_znv(flags_in, dst_val & source_reg, 1'h0);
      end
      mal_pkg::OP_OR, mal_pkg::OP_BITWISE_DISJ_CONST, mal_pkg::OP_SET_MASK_BITS: begin
        res_d = {8'h00, dst_val | source_reg};
        fl_d = fn_znv(flags_in, dst_val | source_reg, 1'h0);
      end
      mal_pkg::OP_XOR_REGS: begin
        res_d = {8'h00, dst_val ^ source_reg};
        fl_d = fn_znv(flags_in, dst_val ^ source_reg, 1'h0);
      end
      mal_pkg::OP_CLEAR_MASK_BITS: begin
        res_d = {8'h00, dst_val & ~source_reg};
        fl_d = fn_znv(flags_in, dst_val & ~source_reg, 1'h0);
      end
      mal_pkg::OP_ZERO_SIGN_CHECK: begin
        res_d = {8'h00, dst_val};
        fl_d = fn_znv(flags_in, dst_val, 1'h0);
      end
      mal_pkg::OP_BIT_INVERSION: begin
        res_d = {8'h00, ~dst_val};
        fl_d = fn_znv(flags_in, ~dst_val, 1'h0);
        fl_d[`MAL_FLAG_C] = 1'h1;
      end
      mal_pkg::OP_PLUS_ONE: begin
        res_d = {8'h00, dst_val + 8'h01};
        fl_d = fn_znv(flags_in, dst_val + 8'h01, dst_val == 8'h7F);
      end
      mal_pkg::OP_MINUS_ONE: begin
        res_d = {8'h00, dst_val - 8'h01};
        fl_d = fn_znv(flags_in, dst_val - 8'h01, dst_val == 8'h80);
      end
      mal_pkg::OP_ZERO_REGISTER: begin
        res_d = 16'h0000;
        fl_d = fn_znv(flags_in, 8'h00, 1'h0);
      end
      mal_pkg::OP_ALL_ONES_LOAD: begin
        res_d = {8'h00, `MAL_ALL_ONES};
      end
      default: begin
        // Products: carry is the product's top bit before the fractional shift
        res_d = prod_out;
        wide_d = 1'h1;
        prodp_d = 1'h1;
        fl_d[`MAL_FLAG_C] = prod[15];
        fl_d[`MAL_FLAG_Z] = (prod_out == 16'h0000);
      end
    endcase
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      mal_pkg::ST_IDLE: begin
        if (take && two) begin
          state_d = mal_pkg::ST_SECOND;
        end
      end
      mal_pkg::ST_SECOND: begin
        state_d = mal_pkg::ST_IDLE;
      end
      default: begin
        state_d = mal_pkg::ST_IDLE;
      end
    endcase
  end

  wire done_d = (take && !two) || (state_q == mal_pkg::ST_SECOND);
  wire busy_d = (state_d == mal_pkg::ST_SECOND);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= mal_pkg::ST_IDLE;
      done_q <= 1'h0;
      busy_q <= 1'h0;
    end else begin
      state_q <= state_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  // Results are captured when the operation is taken and held until the next one
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      result_q <= `MAL_RST_RESULT;
      flags_q <= `MAL_RST_FLAGS;
      wide_q <= 1'h0;
      product_pair_q <= 1'h0;
    end else if (take) begin
      result_q <= res_d;
      flags_q <= fl_d;
      wide_q <= wide_d;
      product_pair_q <= prodp_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_take_short;
    take && !fn_two_cycle(op);
  endsequence
  sequence s_take_long;
    take && fn_two_cycle(op);
  endsequence
  sequence s_long_finish;
    busy_q && !done_q ##1 done_q && !busy_q;
  endsequence

  property p_short_latency;
    s_take_short |-> ##1 done_q && !busy_q;
  endproperty
  a_short_latency: assert property (p_short_latency) else $error("one-cycle op not done after one cycle");

  property p_long_latency;
    s_take_long |-> ##1 s_long_finish;
  endproperty
  a_long_latency: assert property (p_long_latency) else $error("two-cycle op not done after two cycles");

  property p_add_carry;
    take && op == mal_pkg::OP_ADD_CARRY |->
      ##1 result_q[7:0] == 8'($past(dst_val) + $past(source_reg) + {7'h00, $past(flags_in[`MAL_FLAG_C])});
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add with carry result wrong");

  property p_pair_add;
    s_take_long and op == mal_pkg::OP_PAIR_PLUS_IMMEDIATE |->
      ##2 done_q && result_q == 16'($past({dst_hi_val, dst_val}, 2) + {10'h000, $past(source_reg[5:0], 2)});
  endproperty
  a_pair_add: assert property (p_pair_add) else $error("pair add result wrong at done");

  property p_sub_borrow;
    take && op == mal_pkg::OP_SUB |-> ##1 flags_q[`MAL_FLAG_C] == ($past(source_reg) > $past(dst_val));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("subtract borrow flag wrong");

  property p_const_borrow_zero;
    take && op == mal_pkg::OP_DIFFERENCE_CONST_BORROW && !flags_in[`MAL_FLAG_Z] |-> ##1 !flags_q[`MAL_FLAG_Z];
  endproperty
  a_const_borrow_zero: assert property (p_const_borrow_zero) else $error("borrow chain set zero flag");

  property p_pair_sub;
    s_take_long and op == mal_pkg::OP_PAIR_MINUS_IMMEDIATE |->
      ##2 done_q && result_q == 16'($past({dst_hi_val, dst_val}, 2) - {10'h000, $past(source_reg[5:0], 2)});
  endproperty
  a_pair_sub: assert property (p_pair_sub) else $error("pair subtract result wrong at done");

  property p_and_flags;
    take && op == mal_pkg::OP_AND |->
      ##1 !flags_q[`MAL_FLAG_V] && flags_q[`MAL_FLAG_C] == $past(flags_in[`MAL_FLAG_C]);
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("and changed carry or left overflow set");

  property p_xor;
    take && op == mal_pkg::OP_XOR_REGS |-> ##1 result_q[7:0] == ($past(dst_val) ^ $past(source_reg));
  endproperty
  a_xor: assert property (p_xor) else $error("xor result wrong");

  property p_clear_mask;
    take && op == mal_pkg::OP_CLEAR_MASK_BITS |-> ##1 (result_q[7:0] & $past(source_reg)) == 8'h00;
  endproperty
  a_clear_mask: assert property (p_clear_mask) else $error("clear mask left bits set");

  property p_test;
    take && op == mal_pkg::OP_ZERO_SIGN_CHECK |->
      ##1 result_q[7:0] == $past(dst_val) && flags_q[`MAL_FLAG_Z] == ($past(dst_val) == 8'h00);
  endproperty
  a_test: assert property (p_test) else $error("test altered value or zero flag");

  property p_mul;
    s_take_long and op == mal_pkg::OP_UNSIGNED_PRODUCT |->
      ##2 done_q && product_pair_q && result_q == ({8'h00, $past(dst_val, 2)} * {8'h00, $past(source_reg, 2)});
  endproperty
  a_mul: assert property (p_mul) else $error("unsigned product wrong");

  property p_fractional_unsigned_product;
    s_take_long and op == mal_pkg::OP_FRACTIONAL_UNSIGNED_PRODUCT |-> ##2 done_q && !result_q[0];
  endproperty
  a_fractional_unsigned_product: assert property (p_fractional_unsigned_product) else $error("fractional product not shifted");

  property p_ones;
    take && op == mal_pkg::OP_ALL_ONES_LOAD |-> ##1 result_q[7:0] == 8'hFF && flags_q == $past(flags_in);
  endproperty
  a_ones: assert property (p_ones) else $error("all ones load changed flags");
endmodule
`default_nettype wire

/* File: common/mal_defs.svh */
// Constants for the arithmetic and logic unit: flag positions, reset values, latencies
`ifndef MAL_DEFS_SVH
`define MAL_DEFS_SVH
`define MAL_FLAG_C 0
`define MAL_FLAG_Z 1
`define MAL_FLAG_N 2
`define MAL_FLAG_V 3
`define MAL_FLAG_S 4
`define MAL_FLAG_H 5
`define MAL_RST_RESULT 16'h0000
`define MAL_RST_FLAGS 8'h00
`define MAL_ALL_ONES 8'hFF
`define MAL_IMM_BITS 6
`define MAL_LAT_SHORT 1
`define MAL_LAT_LONG 2
`endif

/* File: common/mal_pkg.sv */
// Types shared by the arithmetic and logic unit and its bench
package mal_pkg;
  typedef enum logic [4:0] {
    OP_ADD, OP_ADD_CARRY, OP_PAIR_PLUS_IMMEDIATE, OP_SUB, OP_DIFFERENCE_CONST,
    OP_DIFFERENCE_WITH_BORROW, OP_DIFFERENCE_CONST_BORROW, OP_PAIR_MINUS_IMMEDIATE,
    OP_AND, OP_BITWISE_CONJ_CONST, OP_OR, OP_BITWISE_DISJ_CONST, OP_XOR_REGS,
    OP_BIT_INVERSION, OP_TWOS_COMPLEMENT_NEGATE, OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS,
    OP_PLUS_ONE, OP_MINUS_ONE, OP_ZERO_SIGN_CHECK, OP_ZERO_REGISTER, OP_ALL_ONES_LOAD,
    OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_PRODUCT,
    OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT
  } mal_op_e;
  typedef enum logic [0:0] {ST_IDLE, ST_SECOND} mal_state_e;
endpackage

/* File: sim/mal_tb.sv */
// Self-checking bench for the arithmetic and logic unit
`timescale 1ns/1ps
`default_nettype none
`include "mal_defs.svh"
module testbench;
  logic clock;
  logic sys_rst;
  logic start;
  mal_pkg::mal_op_e op;
  logic [7:0] dst_val;
  logic [7:0] dst_hi_val;
  logic [7:0] source_reg;
  logic [7:0] flags_in;
  logic busy_q;
  logic done_q;
  logic [15:0] result_q;
  logic [7:0] flags_q;
  logic wide_q;
  logic product_pair_q;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;

  mal_alu dut (
    .clock(clock),
    .sys_rst(sys_rst),
    .start(start),
    .op(op),
    .dst_val(dst_val),
    .dst_hi_val(dst_hi_val),
    .source_reg(source_reg),
    .flags_in(flags_in),
    .busy_q(busy_q),
    .done_q(done_q),
    .result_q(result_q),
    .flags_q(flags_q),
    .wide_q(wide_q),
    .product_pair_q(product_pair_q)
  );

  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // About 130 cycles are expected; a hang stops here
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic issue(input mal_pkg::mal_op_e o, input logic [7:0] d, input logic [7:0] dh,
                       input logic [7:0] s, input logic [7:0] f);
    @(negedge clock);
    start = 1'h1;
    op = o;
    dst_val = d;
    dst_hi_val = dh;
    source_reg = s;
    flags_in = f;
  endtask

  // One operation end to end; wide results are exactly the two-cycle ones
  task automatic run(input mal_pkg::mal_op_e o, input logic [7:0] d, input logic [7:0] dh, input logic [7:0] s,
                     input logic [7:0] f, input logic [15:0] r, input logic [7:0] fl, input int lat, input logic pp);
    int n;
    issue(o, d, dh, s, f);
    @(negedge clock);
    start = 1'h0;
    n = 1;
    chk("busy", {15'h0000, lat > 1}, {15'h0000, busy_q});
    while (done_q !== 1'h1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    chk("latency", 16'(lat), 16'(n));
    chk("result", r, result_q);
    chk("flags", {8'h00, fl}, {8'h00, flags_q});
    chk("wide", {15'h0000, lat > 1}, {15'h0000, wide_q});
    chk("product pair", {15'h0000, pp}, {15'h0000, product_pair_q});
    @(negedge clock);
    chk("done pulse", 16'h0000, {15'h0000, done_q});
  endtask

  task automatic chk_zero();
    chk("status bits", 16'h0000, {busy_q, done_q, wide_q, product_pair_q, 12'h000});
    chk("result", 16'h0000, result_q);
    chk("flags", 16'h0000, {8'h00, flags_q});
  endtask

  task automatic t_reset();
    @(negedge clock);
    chk_zero();
    issue(mal_pkg::OP_PAIR_MINUS_IMMEDIATE, 8'h00, 8'h01, 8'h01, 8'hC0);
    @(negedge clock);
    start = 1'h0;
    sys_rst = 1'h1;
    @(negedge clock);
    chk_zero();
    sys_rst = 1'h0;
    $display("test reset done");
  endtask

  task automatic t_add_sub();
    run(mal_pkg::OP_ADD, 8'h7F, 8'h00, 8'h01, 8'hC0, 16'h0080, 8'hEC, 1, 1'h0);
    run(mal_pkg::OP_ADD_CARRY, 8'hFF, 8'h00, 8'h00, 8'hC1, 16'h0000, 8'hE3, 1, 1'h0);
    run(mal_pkg::OP_SUB, 8'h00, 8'h00, 8'h01, 8'hC0, 16'h00FF, 8'hF5, 1, 1'h0);
    run(mal_pkg::OP_DIFFERENCE_WITH_BORROW, 8'h05, 8'h00, 8'h04, 8'hC1, 16'h0000, 8'hC0, 1, 1'h0);
    run(mal_pkg::OP_DIFFERENCE_WITH_BORROW, 8'h05, 8'h00, 8'h04, 8'hC3, 16'h0000, 8'hC2, 1, 1'h0);
    run(mal_pkg::OP_DIFFERENCE_CONST, 8'h80, 8'h00, 8'h01, 8'hC0, 16'h007F, 8'hF8, 1, 1'h0);
    run(mal_pkg::OP_DIFFERENCE_CONST_BORROW, 8'h20, 8'h00, 8'h10, 8'hC1, 16'h000F, 8'hE0, 1, 1'h0);
    run(mal_pkg::OP_DIFFERENCE_CONST_BORROW, 8'h10, 8'h00, 8'h0F, 8'hC1, 16'h0000, 8'hE0, 1, 1'h0);
    $display("test add and subtract done");
  endtask

  task automatic t_pair();
    run(mal_pkg::OP_PAIR_PLUS_IMMEDIATE, 8'hFF, 8'hFF, 8'h01, 8'hC0, 16'h0000, 8'hC3, 2, 1'h0);
    run(mal_pkg::OP_PAIR_PLUS_IMMEDIATE, 8'hFF, 8'h7F, 8'hC1, 8'hC0, 16'h8000, 8'hCC, 2, 1'h0);
    run(mal_pkg::OP_PAIR_MINUS_IMMEDIATE, 8'h00, 8'h00, 8'h01, 8'hC0, 16'hFFFF, 8'hD5, 2, 1'h0);
    run(mal_pkg::OP_PAIR_MINUS_IMMEDIATE, 8'h00, 8'h80, 8'h3F, 8'hE0, 16'h7FC1, 8'hF8, 2, 1'h0);
    $display("test pair done");
  endtask

  task automatic t_logic();
    run(mal_pkg::OP_AND, 8'hF0, 8'h00, 8'h8F, 8'hFF, 16'h0080, 8'hF5, 1, 1'h0);
    run(mal_pkg::OP_BITWISE_CONJ_CONST, 8'h0F, 8'h00, 8'hF0, 8'hFF, 16'h0000, 8'hE3, 1, 1'h0);
    run(mal_pkg::OP_OR, 8'h00, 8'h00, 8'h00, 8'hC0, 16'h0000, 8'hC2, 1, 1'h0);
    run(mal_pkg::OP_BITWISE_DISJ_CONST, 8'h01, 8'h00, 8'h80, 8'hFF, 16'h0081, 8'hF5, 1, 1'h0);
    run(mal_pkg::OP_XOR_REGS, 8'hAA, 8'h00, 8'hAA, 8'hC8, 16'h0000, 8'hC2, 1, 1'h0);
    run(mal_pkg::OP_SET_MASK_BITS, 8'h01, 8'h00, 8'h02, 8'hC0, 16'h0003, 8'hC0, 1, 1'h0);
    run(mal_pkg::OP_CLEAR_MASK_BITS, 8'hFF, 8'h00, 8'h80, 8'hC0, 16'h007F, 8'hC0, 1, 1'h0);
    run(mal_pkg::OP_ZERO_SIGN_CHECK, 8'h80, 8'h00, 8'h00, 8'hC0, 16'h0080, 8'hD4, 1, 1'h0);
    $display("test logic done");
  endtask

  task automatic t_unary();
    run(mal_pkg::OP_BIT_INVERSION, 8'h55, 8'h00, 8'h00, 8'hC0, 16'h00AA, 8'hD5, 1, 1'h0);
    run(mal_pkg::OP_TWOS_COMPLEMENT_NEGATE, 8'h80, 8'h00, 8'h00, 8'hC0, 16'h0080, 8'hCD, 1, 1'h0);
    run(mal_pkg::OP_PLUS_ONE, 8'h7F, 8'h00, 8'h00, 8'hC1, 16'h0080, 8'hCD, 1, 1'h0);
    run(mal_pkg::OP_MINUS_ONE, 8'h80, 8'h00, 8'h00, 8'hC0, 16'h007F, 8'hD8, 1, 1'h0);
    run(mal_pkg::OP_ZERO_REGISTER, 8'h5A, 8'h00, 8'h00, 8'hC4, 16'h0000, 8'hC2, 1, 1'h0);
    run(mal_pkg::OP_ALL_ONES_LOAD, 8'h00, 8'h00, 8'h00, 8'h3B, 16'h00FF, 8'h3B, 1, 1'h0);
    $display("test unary done");
  endtask

  task automatic t_product();
    run(mal_pkg::OP_UNSIGNED_PRODUCT, 8'hFF, 8'h00, 8'hFF, 8'hC0, 16'hFE01, 8'hC1, 2, 1'h1);
    run(mal_pkg::OP_UNSIGNED_PRODUCT, 8'h00, 8'h00, 8'h37, 8'hC0, 16'h0000, 8'hC2, 2, 1'h1);
    run(mal_pkg::OP_SIGNED_PRODUCT, 8'h80, 8'h00, 8'h01, 8'hC0, 16'hFF80, 8'hC1, 2, 1'h1);
    run(mal_pkg::OP_MIXED_PRODUCT, 8'hFF, 8'h00, 8'hFF, 8'hC0, 16'hFF01, 8'hC1, 2, 1'h1);
    run(mal_pkg::OP_FRACTIONAL_UNSIGNED_PRODUCT, 8'hFF, 8'h00, 8'hFF, 8'hC0, 16'hFC02, 8'hC1, 2, 1'h1);
    run(mal_pkg::OP_FRACTIONAL_UNSIGNED_PRODUCT, 8'h00, 8'h00, 8'h80, 8'hC0, 16'h0000, 8'hC2, 2, 1'h1);
    run(mal_pkg::OP_FRACTIONAL_SIGNED_PRODUCT, 8'h80, 8'h00, 8'h80, 8'hC0, 16'h8000, 8'hC0, 2, 1'h1);
    run(mal_pkg::OP_FRACTIONAL_MIXED_PRODUCT, 8'h80, 8'h00, 8'h80, 8'hC0, 16'h8000, 8'hC1, 2, 1'h1);
    $display("test product done");
  endtask

  task automatic t_back_to_back();
    issue(mal_pkg::OP_ADD, 8'h01, 8'h00, 8'h01, 8'hC0);
    issue(mal_pkg::OP_SUB, 8'h05, 8'h00, 8'h02, 8'hC0);
    chk("done", 16'h0001, {15'h0000, done_q});
    chk("result", 16'h0002, result_q);
    @(negedge clock);
    start = 1'h0;
    chk("done", 16'h0001, {15'h0000, done_q});
    chk("result", 16'h0003, result_q);
    $display("test back to back done");
  endtask

  task automatic t_refuse();
    issue(mal_pkg::OP_PAIR_PLUS_IMMEDIATE, 8'h10, 8'h12, 8'h05, 8'hC0);
    issue(mal_pkg::OP_ALL_ONES_LOAD, 8'h00, 8'h00, 8'h00, 8'h3B);
    chk("busy", 16'h0001, {15'h0000, busy_q});
    @(negedge clock);
    start = 1'h0;
    chk("done", 16'h0001, {15'h0000, done_q});
    chk("result", 16'h1215, result_q);
    chk("flags", 16'h00C0, {8'h00, flags_q});
    @(negedge clock);
    chk("done", 16'h0000, {15'h0000, done_q});
    chk("result", 16'h1215, result_q);
    $display("test refuse done");
  endtask

  initial begin
    sys_rst = 1'h1;
    start = 1'h0;
    op = mal_pkg::OP_ADD;
    dst_val = 8'h00;
    dst_hi_val = 8'h00;
    source_reg = 8'h00;
    flags_in = 8'h00;
    repeat (8) @(negedge clock);
    sys_rst = 1'h0;
    t_reset();
    t_add_sub();
    t_pair();
    t_logic();
    t_unary();
    t_product();
    t_back_to_back();
    t_refuse();
    close_out();
  end
endmodule
`default_nettype wire
